// ===== fssf_char_rx.sv
module fssf_char_rx
    import fssf_pkg::*;
#(
    parameter bit PARITY_ODD = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_stb,
    input wire logic [3:0] i_pos,
    input wire logic i_bit,
    output logic o_char_stb,
    output logic [7:0] o_char,
    output logic o_char_ok
);
    logic [7:0] data_r, data_nxt;
    logic ok_r, ok_nxt;
    logic stb_r, stb_nxt;

    always_comb begin
        data_nxt = data_r;
        ok_nxt = ok_r;
        stb_nxt = 1'b0;
        if (i_stb) begin
            if (i_pos == FSSF_POS_START) begin
                ok_nxt = ~i_bit;
            end else if (i_pos <= FSSF_POS_DATA7) begin
                data_nxt[3'(i_pos - FSSF_POS_DATA0)] = i_bit;
            end else if (i_pos == FSSF_POS_PAR) begin
                ok_nxt = ok_r & (i_bit == ((^data_r) ^ PARITY_ODD));
            end else begin
                ok_nxt = ok_r & i_bit;
            end
            stb_nxt = (i_pos == FSSF_POS_LAST);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            data_r <= 8'h00;
            ok_r <= 1'b0;
            stb_r <= 1'b0;
        end else begin
            data_r <= data_nxt;
            ok_r <= ok_nxt;
            stb_r <= stb_nxt;
        end
    end

    assign o_char_stb = stb_r;
    assign o_char = data_r;
    assign o_char_ok = ok_r;
endmodule // fssf_char_rx

// ===== fssf_keypad.sv
// Operation
// - The channel repeats frames of exactly 64 message blocks numbered from the frame start.
// - Each block is a 256-bit flag field followed by a message field, giving 16,384 flag positions.
// - The keypad holds a fixed directory address picking one unique flag position per frame.
// - From each frame boundary the keypad counts received flag-field bits until its own position.
// - At its own flag position the keypad sends one pulse if a request is pending, else stays silent.
// - A keypad polled by its own address sends keystrokes and status in the very next message field.
// - Control sends transmit and receive indirect addresses, which the keypad hands to the data buffer.
// - A message field is six 8-bit characters, each start, eight data, parity and two stop bits.
// - The channel bit rate is 25 kb/s in both directions.
module fssf_keypad
    import fssf_pkg::*;
#(
    parameter int BIT_CYCLES_P = FSSF_BIT_CYCLES,
    parameter bit PARITY_ODD = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_rx_line,
    input wire logic i_frame_sync,
    input wire logic [13:0] i_dir_addr,
    input wire logic i_key_req,
    input wire logic [39:0] i_keys,
    input wire logic [7:0] i_status,
    output logic o_tx_line,
    output logic o_tx_en,
    output logic o_req_pending,
    output logic o_polled,
    output logic o_ind_valid,
    output logic [15:0] o_ind_tx_addr,
    output logic [15:0] o_ind_rx_addr
);
    localparam int PH_W = $clog2(BIT_CYCLES_P);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(BIT_CYCLES_P - 1);
    localparam logic [PH_W-1:0] PH_MID = PH_W'(BIT_CYCLES_P / 2);

    // rx line, frame sync and directory address pins cross in through two flops; the first stage feeds only the second
    logic rx_s1, rx_s2, fs_s1, fs_s2, fs_d;
    logic [13:0] addr_s1, addr_s2;
    always_ff @(posedge i_sys_clk) begin
        rx_s1 <= i_rx_line;
        rx_s2 <= rx_s1;
        fs_s1 <= i_frame_sync;
        fs_s2 <= fs_s1;
        fs_d <= fs_s2;
        addr_s1 <= i_dir_addr;
        addr_s2 <= addr_s1;
    end

    fssf_field_t field_r, field_nxt;
    logic [PH_W-1:0] phase_r, phase_nxt;
    logic [5:0] block_r, block_nxt;
    logic [7:0] fbit_r, fbit_nxt;
    logic [2:0] char_r, char_nxt;
    logic [3:0] cpos_r, cpos_nxt;
    logic [47:0] msg_r, msg_nxt;
    logic [47:0] reply_r, reply_nxt;
    logic msg_ok_r, msg_ok_nxt;
    logic arm_r, arm_nxt, act_r, act_nxt;
    logic pend_r, pend_nxt;
    logic polled_r, polled_nxt;
    logic indv_r, indv_nxt;
    logic [15:0] ind_tx_r, ind_tx_nxt, ind_rx_r, ind_rx_nxt;
    logic tx_r, tx_nxt, txen_r, txen_nxt;
    logic c_stb, c_ok;
    logic [7:0] c_char;
    logic sync_edge, bit_end, sample;

    assign sync_edge = fs_s2 & ~fs_d;
    assign bit_end = (field_r != FSSF_IDLE) && (phase_r == PH_LAST);
    assign sample = (field_r == FSSF_MSG) && (phase_r == PH_MID);

    fssf_char_rx #(
        .PARITY_ODD(PARITY_ODD)
    ) u_char_rx (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_stb(sample),
        .i_pos(cpos_r),
        .i_bit(rx_s2),
        .o_char_stb(c_stb),
        .o_char(c_char),
        .o_char_ok(c_ok)
    );

    function automatic logic char_bit(input logic [47:0] d, input logic [2:0] c, input logic [3:0] p);
        logic [7:0] ch;
        ch = d[{c, 3'b000} +: 8];
        if (p == FSSF_POS_START) begin
            char_bit = 1'b0;
        end else if (p <= FSSF_POS_DATA7) begin
            char_bit = ch[3'(p - FSSF_POS_DATA0)];
        end else if (p == FSSF_POS_PAR) begin
            char_bit = (^ch) ^ PARITY_ODD;
        end else begin
            char_bit = 1'b1;
        end
    endfunction

    always_comb begin
        logic [47:0] m;
        logic ok;
        m = msg_r;
        ok = msg_ok_r;
        field_nxt = field_r;
        phase_nxt = phase_r;
        block_nxt = block_r;
        fbit_nxt = fbit_r;
        char_nxt = char_r;
        cpos_nxt = cpos_r;
        msg_nxt = msg_r;
        msg_ok_nxt = msg_ok_r;
        reply_nxt = reply_r;
        arm_nxt = arm_r;
        act_nxt = act_r;
        pend_nxt = pend_r;
        polled_nxt = 1'b0;
        indv_nxt = 1'b0;
        ind_tx_nxt = ind_tx_r;
        ind_rx_nxt = ind_rx_r;
        // bit timing restarts at every frame boundary so counts never drift
        if (sync_edge) begin
            field_nxt = FSSF_FLAG;
            phase_nxt = '0;
            block_nxt = FSSF_BLOCK_FIRST;
            fbit_nxt = 8'h00;
            char_nxt = 3'h0;
            cpos_nxt = 4'h0;
        end else if (field_r != FSSF_IDLE) begin
            phase_nxt = bit_end ? '0 : phase_r + 1'b1;
            if (bit_end && field_r == FSSF_FLAG) begin
                fbit_nxt = fbit_r + 8'h01;
                if (fbit_r == FSSF_FBIT_LAST) begin
                    field_nxt = FSSF_MSG;
                    act_nxt = arm_r;
                    arm_nxt = 1'b0;
                end
            end else if (bit_end) begin
                cpos_nxt = cpos_r + 4'h1;
                if (cpos_r == FSSF_POS_LAST) begin
                    cpos_nxt = 4'h0;
                    char_nxt = char_r + 3'h1;
                    if (char_r == FSSF_CHAR_LAST) begin
                        char_nxt = 3'h0;
                        field_nxt = FSSF_FLAG;
                        block_nxt = block_r + 6'h01;
                        if (act_r) begin
                            act_nxt = 1'b0;
                            pend_nxt = 1'b0;
                        end
                    end
                end
            end
        end
        if (c_stb) begin
            m[{char_r, 3'b000} +: 8] = c_char;
            ok = ((char_r == 3'h0) | msg_ok_r) & c_ok;
            msg_nxt = m;
            msg_ok_nxt = ok;
            if (char_r == FSSF_CHAR_LAST && ok && m[FSSF_AHI_LSB +: 6] == addr_s2[13:8]
                && m[FSSF_ALO_LSB +: 8] == addr_s2[7:0]) begin
                if (m[FSSF_TYPE_LSB +: 2] == FSSF_TYPE_POLL) begin
                    arm_nxt = 1'b1;
                    polled_nxt = 1'b1;
                    reply_nxt = {i_status, i_keys};
                end else if (m[FSSF_TYPE_LSB +: 2] == FSSF_TYPE_IND) begin
                    indv_nxt = 1'b1;
                    ind_tx_nxt = m[FSSF_IND_TX_LSB +: 16];
                    ind_rx_nxt = m[FSSF_IND_RX_LSB +: 16];
                end
            end
        end
        // a keystroke arriving with the clear is kept
        if (i_key_req) begin
            pend_nxt = 1'b1;
        end
        // outputs follow the counters' next values so they line up with the bit
        tx_nxt = 1'b0;
        txen_nxt = 1'b0;
        // the send decision is taken at the bit boundary only, so a late keystroke never makes a short pulse
        if (field_nxt == FSSF_FLAG && block_nxt == addr_s2[13:8] && fbit_nxt == addr_s2[7:0]
            && ((sync_edge || bit_end) ? pend_nxt : tx_r)) begin
            tx_nxt = 1'b1;
            txen_nxt = 1'b1;
        end else if (field_nxt == FSSF_MSG && act_nxt) begin
            tx_nxt = char_bit(reply_nxt, char_nxt, cpos_nxt);
            txen_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            field_r <= FSSF_IDLE;
            phase_r <= '0;
            block_r <= 6'h00;
            fbit_r <= 8'h00;
            char_r <= 3'h0;
            cpos_r <= 4'h0;
            msg_r <= 48'h0;
            msg_ok_r <= 1'b0;
            reply_r <= 48'h0;
            arm_r <= 1'b0;
            act_r <= 1'b0;
            pend_r <= 1'b0;
            polled_r <= 1'b0;
            indv_r <= 1'b0;
            ind_tx_r <= 16'h0;
            ind_rx_r <= 16'h0;
            tx_r <= 1'b0;
            txen_r <= 1'b0;
        end else begin
            field_r <= field_nxt;
            phase_r <= phase_nxt;
            block_r <= block_nxt;
            fbit_r <= fbit_nxt;
            char_r <= char_nxt;
            cpos_r <= cpos_nxt;
            msg_r <= msg_nxt;
            msg_ok_r <= msg_ok_nxt;
            reply_r <= reply_nxt;
            arm_r <= arm_nxt;
            act_r <= act_nxt;
            pend_r <= pend_nxt;
            polled_r <= polled_nxt;
            indv_r <= indv_nxt;
            ind_tx_r <= ind_tx_nxt;
            ind_rx_r <= ind_rx_nxt;
            tx_r <= tx_nxt;
            txen_r <= txen_nxt;
        end
    end

    assign o_tx_line = tx_r;
    assign o_tx_en = txen_r;
    assign o_req_pending = pend_r;
    assign o_polled = polled_r;
    assign o_ind_valid = indv_r;
    assign o_ind_tx_addr = ind_tx_r;
    assign o_ind_rx_addr = ind_rx_r;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    AST_BLOCK_WRAP: assert property (block_r != $past(block_r) && !$past(sync_edge)
        |-> block_r == $past(block_r) + 6'h01 && fbit_r == 8'h00) else $error("block step wrong");
    AST_FLAG_LEN: assert property (field_r == FSSF_MSG && $past(field_r) == FSSF_FLAG
        |-> $past(fbit_r) == FSSF_FBIT_LAST && cpos_r == 4'h0) else $error("flag field length");
    AST_MSG_LEN: assert property (field_r == FSSF_FLAG && $past(field_r) == FSSF_MSG && !$past(sync_edge)
        |-> $past(char_r) == FSSF_CHAR_LAST && $past(cpos_r) == FSSF_POS_LAST) else $error("msg length");
    AST_SLOT_ONLY: assert property (o_tx_en && !act_r |-> field_r == FSSF_FLAG && o_tx_line
        && block_r == addr_s2[13:8] && fbit_r == addr_s2[7:0]) else $error("pulse off slot");
    // with the slot check above this pins a flag pulse to exactly one bit period
    AST_PULSE_ONE_BIT: assert property ($changed(o_tx_en) |-> phase_r == '0)
        else $error("tx edge off bit boundary");
    AST_POLL_ARM: assert property (o_polled |-> arm_r && field_r == FSSF_MSG
        && char_r == FSSF_CHAR_LAST) else $error("poll not armed");
    AST_REPLY_NEXT: assert property ($fell(arm_r) |-> act_r && field_r == FSSF_MSG
        && o_tx_en && !o_tx_line) else $error("reply not started");
    AST_PEND_CLEAR: assert property ($fell(act_r) && !$past(i_key_req) && !$past(sync_edge)
        |-> !o_req_pending) else $error("pending not cleared");
    AST_KEY_SET: assert property (i_key_req |=> o_req_pending) else $error("request lost");
    AST_PHASE_RANGE: assert property (field_r != FSSF_IDLE
        |-> phase_r <= PH_LAST && (phase_r != '0 || $past(phase_r) == PH_LAST || $past(sync_edge))
        ) else $error("bit timer");
    AST_IND_FROM_MSG: assert property (o_ind_valid |-> $past(field_r) == FSSF_MSG
        && $past(char_r) == FSSF_CHAR_LAST) else $error("indirect outside msg");
endmodule // fssf_keypad

// ===== fssf_pkg.sv
package fssf_pkg;
    localparam int FSSF_BLOCKS = 64;
    localparam int FSSF_FLAG_BITS = 256;
    localparam int FSSF_MSG_CHARS = 6;
    localparam int FSSF_CHAR_BITS = 12;
    localparam int FSSF_ADDR_W = 14;
    localparam int FSSF_CLK_HZ = 200_000_000;
    localparam int FSSF_BIT_RATE_BPS = 25_000;
    localparam int FSSF_BIT_CYCLES = FSSF_CLK_HZ / FSSF_BIT_RATE_BPS;
    // positions inside one 12-bit character frame
    localparam logic [3:0] FSSF_POS_START = 4'h0;
    localparam logic [3:0] FSSF_POS_DATA0 = 4'h1;
    localparam logic [3:0] FSSF_POS_DATA7 = 4'h8;
    localparam logic [3:0] FSSF_POS_PAR = 4'h9;
    localparam logic [3:0] FSSF_POS_LAST = 4'hB;
    localparam logic [2:0] FSSF_CHAR_LAST = 3'h5;
    localparam logic [7:0] FSSF_FBIT_LAST = 8'hFF;
    localparam logic [5:0] FSSF_BLOCK_FIRST = 6'h00;
    // message field layout, character 0 in the low byte
    localparam int FSSF_TYPE_LSB = 6;
    localparam int FSSF_AHI_LSB = 0;
    localparam int FSSF_ALO_LSB = 8;
    localparam int FSSF_IND_TX_LSB = 16;
    localparam int FSSF_IND_RX_LSB = 32;
    localparam logic [1:0] FSSF_TYPE_POLL = 2'h0;
    localparam logic [1:0] FSSF_TYPE_IND = 2'h1;
    typedef enum logic [1:0] {
        FSSF_IDLE = 2'b00,
        FSSF_FLAG = 2'b01,
        FSSF_MSG = 2'b10
    } fssf_field_t;
endpackage

// ===== fssf_poller_model.sv
module fssf_poller_model
    import fssf_pkg::*;
#(
    parameter int BITC = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_go,
    input wire logic i_send,
    input wire logic [47:0] i_msg,
    input wire logic i_tx_line,
    input wire logic i_tx_en,
    output logic o_rx_line,
    output logic o_frame_sync,
    output logic o_flag_seen,
    output logic [13:0] o_flag_pos,
    output logic o_rep_valid,
    output logic [47:0] o_rep,
    output logic o_rep_ok
);
    int ph_r = 0;
    int bn_r = 0;
    logic [5:0] blk_r = 6'h00;
    logic run_r = 1'b0;
    logic poll_r = 1'b0;
    logic send_r = 1'b0;
    logic got_r = 1'b0;
    logic [71:0] fld_r = '1;
    logic [71:0] cap_r = '0;
    logic ok;
    initial begin
        {o_frame_sync, o_flag_seen, o_rep_valid, o_rep_ok} = 4'h0;
        o_flag_pos = 14'h0000;
        o_rep = 48'h0;
    end
    function automatic logic [71:0] enc(input logic [47:0] w);
        for (int i = 0; i < 6; i++) begin
            enc[12*i +: 12] = {2'b11, ^w[8*i +: 8], w[8*i +: 8], 1'b0};
        end
    endfunction
    // flag bits toggle so that a receiver stuck on one level cannot pass
    assign o_rx_line = !run_r || (bn_r < 256 ? bn_r[0] : fld_r[bn_r - 256]);
    always_comb begin
        ok = 1'b1;
        for (int i = 0; i < 6; i++) begin
            ok &= !cap_r[12*i] && cap_r[12*i+11 -: 2] == 2'b11 && !(^cap_r[12*i +: 10]);
        end
    end
    always @(posedge i_sys_clk) begin
        o_flag_seen <= 1'b0;
        o_rep_valid <= 1'b0;
        if (i_send) begin
            send_r <= 1'b1;
        end
        if (i_go) begin
            run_r <= 1'b1;
            o_frame_sync <= 1'b1;
            ph_r <= BITC - 1;
            bn_r <= 327;
            blk_r <= 6'h3F;
        end else if (run_r && ph_r != BITC - 1) begin
            ph_r <= ph_r + 1;
            if (ph_r == BITC / 2 && i_tx_en === 1'b1) begin
                if (bn_r < 256) begin
                    o_flag_seen <= 1'b1;
                    o_flag_pos <= {blk_r, bn_r[7:0]};
                    poll_r <= 1'b1;
                end else begin
                    got_r <= 1'b1;
                end
            end
            if (ph_r == BITC / 2 && bn_r >= 256) begin
                cap_r[bn_r - 256] <= i_tx_line;
            end
        end else if (run_r) begin
            ph_r <= 0;
            bn_r <= (bn_r == 327) ? 0 : bn_r + 1;
            if (bn_r == 8) begin
                o_frame_sync <= 1'b0;
            end
            if (bn_r == 327) begin
                blk_r <= blk_r + 6'h01;
                o_rep_valid <= got_r;
                o_rep_ok <= ok;
                got_r <= 1'b0;
                for (int i = 0; i < 6; i++) begin
                    o_rep[8*i +: 8] <= cap_r[12*i+1 +: 8];
                end
            end
            // a pending poll outranks a queued message: the requester waits one field only
            if (bn_r == 255) begin
                fld_r <= poll_r ? enc({32'h0, o_flag_pos[7:0], FSSF_TYPE_POLL, o_flag_pos[13:8]}) :
                         send_r ? enc(i_msg) : '1;
                poll_r <= 1'b0;
                send_r <= send_r && poll_r;
            end
        end
    end
endmodule // fssf_poller_model

// ===== tb.sv
module tb
    import fssf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BITC = 8;
    localparam int BLK = 328 * BITC;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic key_req = 1'b0;
    logic go = 1'b0;
    logic send = 1'b0;
    logic hit = 1'b0;
    logic [13:0] dir_addr = 14'h0003;
    logic [39:0] keys = 40'h0;
    logic [7:0] status = 8'h00;
    logic [47:0] msg = 48'h0;
    logic rx_line, frame_sync, tx_line, tx_en, pend, polled, ind_valid, flag_seen, rep_valid, rep_ok;
    logic [13:0] flag_pos;
    logic [15:0] ind_tx, ind_rx;
    logic [47:0] rep;
    int mismatches = 0;
    int comparisons = 0;
    always #2.5 i_sys_clk = ~i_sys_clk;
    fssf_keypad #(.BIT_CYCLES_P(BITC), .PARITY_ODD(1'b0)) DUT (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rx_line(rx_line), .i_frame_sync(frame_sync),
        .i_dir_addr(dir_addr), .i_key_req(key_req), .i_keys(keys), .i_status(status),
        .o_tx_line(tx_line), .o_tx_en(tx_en), .o_req_pending(pend), .o_polled(polled),
        .o_ind_valid(ind_valid), .o_ind_tx_addr(ind_tx), .o_ind_rx_addr(ind_rx));
    fssf_poller_model #(.BITC(BITC)) poller (
        .i_sys_clk(i_sys_clk), .i_go(go), .i_send(send), .i_msg(msg), .i_tx_line(tx_line),
        .i_tx_en(tx_en), .o_rx_line(rx_line), .o_frame_sync(frame_sync), .o_flag_seen(flag_seen),
        .o_flag_pos(flag_pos), .o_rep_valid(rep_valid), .o_rep(rep), .o_rep_ok(rep_ok));
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_for(input int sel, input int lim, input bit must);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge i_sys_clk);
            case (sel)
                0: hit = (flag_seen === 1'b1);
                1: hit = (polled === 1'b1);
                2: hit = (rep_valid === 1'b1);
                default: hit = (ind_valid === 1'b1);
            endcase
        end
        if (must && !hit) begin
            mismatches++;
            $display("MISMATCH wait %0d expected 1 seen 0", sel);
            finish_test();
        end
    endtask
    // a new frame always starts here, so no test has to sit through a full 64-block frame
    task automatic start(input logic with_msg);
        @(negedge i_sys_clk);
        go = 1'b1;
        send = with_msg;
        @(negedge i_sys_clk);
        go = 1'b0;
        send = 1'b0;
    endtask
    task automatic s_silent;
        start(1'b0);
        wait_for(0, 2 * BLK, 0);
        chk("flag", 0, hit);
        chk("tx_en", 0, tx_en);
        $display("done silent");
    endtask
    task automatic s_request;
        dir_addr = 14'h01FF;
        keys = 40'h8E_0F1D_2C3B;
        status = 8'hA7;
        key_req = 1'b1;
        @(negedge i_sys_clk);
        key_req = 1'b0;
        @(negedge i_sys_clk);
        chk("pending", 1, pend);
        msg = {32'h0, 8'hFE, FSSF_TYPE_POLL, 6'h01};
        start(1'b1);
        wait_for(1, BLK + 100, 0);
        chk("foreign_poll", 0, hit);
        wait_for(0, 2 * BLK, 1);
        chk("flag_pos", 14'h01FF, flag_pos);
        wait_for(1, BLK, 1);
        chk("pending_held", 1, pend);
        wait_for(2, 2 * BLK, 1);
        chk("reply", {status, keys}, rep);
        chk("reply_framing", 1, rep_ok);
        // the model closes its field two cycles before the keypad's synchronised view of it
        repeat (4) @(negedge i_sys_clk);
        chk("pending_clr", 0, pend);
        chk("tx_en_end", 0, tx_en);
        $display("done request");
    endtask
    task automatic s_indirect;
        msg = {16'hC3A5, 16'h5A3C, 8'hFF, FSSF_TYPE_IND, 6'h01};
        start(1'b1);
        wait_for(3, 2 * BLK, 1);
        chk("ind_tx", 16'h5A3C, ind_tx);
        chk("ind_rx", 16'hC3A5, ind_rx);
        $display("done indirect");
    endtask
    initial begin
        repeat (6) @(negedge i_sys_clk);
        i_rst = 1'b0;
        @(negedge i_sys_clk);
        chk("tx_en_rst", 0, tx_en);
        chk("pend_rst", 0, pend);
        $display("done reset");
        s_silent();
        s_request();
        s_indirect();
        finish_test();
    end
endmodule // tb
